// >>> tb/codec_model.sv
// Behavioural serial peer that collects 16-bit slot words from the link
`timescale 1ns/1ps
module codec_model
(
  // Clock and reset
  input  wire         mclk,
  input  wire         rstn,
  // Serial link
  input  wire         sck,
  input  wire         fsync,
  input  wire         txd,
  input  wire         txd_oe,
  // Collected words
  output logic [15:0] word_ff,
  output logic [3:0]  slot_ff,
  output logic        word_v_ff
);
  logic        sck_d_ff;
  logic [7:0]  bit_ff;
  logic [15:0] sh_ff;
  // A floating line is pulled high
  wire         line = txd_oe ? txd : 1'b1;
  wire  [15:0] nxt_sh = {sh_ff[14:0], line};
  wire  [7:0]  nxt_bit = fsync ? 8'h01 : bit_ff + 8'h01;
  // Sample on sck rise, count bits from the frame sync, MSB first
  always @(posedge mclk or negedge rstn)
    if (!rstn)
    begin
      sck_d_ff  <= 1'b0;
      bit_ff    <= 8'h00;
      sh_ff     <= 16'h0000;
      word_ff   <= 16'h0000;
      slot_ff   <= 4'h0;
      word_v_ff <= 1'b0;
    end
    else
    begin
      sck_d_ff  <= sck;
      word_v_ff <= 1'b0;
      if (sck && !sck_d_ff)
      begin
        sh_ff  <= nxt_sh;
        bit_ff <= nxt_bit;
        if (nxt_bit[3:0] == 4'h0)
        begin
          word_ff   <= nxt_sh;
          slot_ff   <= nxt_bit[7:4] - 4'h1;
          word_v_ff <= 1'b1;
        end
      end
    end
endmodule

// >>> tb/sck_slot_monitor.sv
// Assertion checker for the serial clock and slot block
`timescale 1ns/1ps
`include "sclk_txslot_map.vh"
module sck_slot_monitor
#(
  parameter ADDR_W = 8
)
(
  // Clock and reset
  input wire              mclk,
  input wire              rstn,
  input wire              ce,
  // Register port
  input wire [ADDR_W-1:0] addr,
  input wire [15:0]       wdata,
  input wire              wr,
  input wire              rd,
  input wire [15:0]       rdata_ff,
  // Serial link
  input wire              ext_master_clock_pin,
  input wire              sck_ff,
  input wire              fsync_ff,
  input wire              txd_ff,
  input wire              txd_oe_ff
);
  // ----------------------------------------------------------------
  // Shadow registers, cycles since a config write, sck run length
  // ----------------------------------------------------------------
  logic [15:0] mode_ff;
  logic [15:0] cks_ff;
  logic [15:0] slot_ff;
  logic [15:0] cfg_ff;
  logic [15:0] run_ff;
  logic        sck_d_ff;
  wire  [5:0]  psc = (cks_ff[12:8] == 5'h00) ? 6'h20 : {1'b0, cks_ff[12:8]};
  wire  [15:0] half = {10'h000, psc} << cks_ff[2:0];
  wire         ws = ce && wr;
  wire         cfg_w = ws && (addr == `OFS_PORT_MODE || addr == `OFS_CLOCK_SELECT
                              || addr == `OFS_SOFT_RESET);
  wire         srst = ws && addr == `OFS_SOFT_RESET && wdata[0];
  // Follow register writes as the block should
  always @(posedge mclk or negedge rstn)
    if (!rstn)
    begin
      mode_ff  <= `RST_PORT_MODE;
      cks_ff   <= `RST_CLOCK_SELECT;
      slot_ff  <= `RST_TX_SLOT;
      cfg_ff   <= 16'h0000;
      run_ff   <= 16'h0000;
      sck_d_ff <= 1'b0;
    end
    else
    begin
      sck_d_ff <= sck_ff;
      run_ff   <= (sck_ff != sck_d_ff) ? 16'h0001 : run_ff + 16'h0001;
      cfg_ff   <= cfg_w ? 16'h0000 : (cfg_ff == 16'hFFFF) ? cfg_ff : cfg_ff + 16'h0001;
      if (ws && addr == `OFS_PORT_MODE)
        mode_ff <= wdata & `MASK_PORT_MODE;
      if (ws && addr == `OFS_CLOCK_SELECT)
        cks_ff <= wdata & `MASK_CLOCK_SELECT;
      if (ws && addr == `OFS_TX_SLOT)
        slot_ff <= wdata & `MASK_TX_SLOT;
      if (srst)
        cks_ff <= `RST_CLOCK_SELECT;
      if (srst)
        slot_ff <= `RST_TX_SLOT;
    end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  chk_cks_readback: assert property (ce && rd && addr == `OFS_CLOCK_SELECT |=> rdata_ff == cks_ff)
    else $error("clock select readback differs");
  chk_slot_readback: assert property (ce && rd && addr == `OFS_TX_SLOT |=> rdata_ff == slot_ff)
    else $error("slot assign readback differs");
  chk_unmapped_zero: assert property (ce && rd && addr == 8'h1C |=> rdata_ff == 16'h0000)
    else $error("unmapped read not zero");
  chk_sck_slave_low: assert property (!mode_ff[15] && cfg_ff > 16'h0002 |-> !sck_ff)
    else $error("serial clock runs outside master mode");
  chk_direct_toggle: assert property (
    mode_ff[15] && cks_ff[15] && cks_ff[14] && cfg_ff > 16'h0004 |-> sck_ff != sck_d_ff)
    else $error("direct clock not at master rate");
  chk_half_period: assert property (
    mode_ff[15] && cks_ff[15] && !cks_ff[14] && sck_ff != sck_d_ff
    && cfg_ff > 2 * half + 4 |-> run_ff == half)
    else $error("divided clock half period wrong");
  chk_txd_on_fall: assert property (
    mode_ff[15] && cfg_ff > 16'h0002 && $changed(txd_ff) |-> $fell(sck_ff))
    else $error("transmit line moved off a falling edge");
  chk_fsync_on_fall: assert property ($rose(fsync_ff) |-> $fell(sck_ff))
    else $error("frame sync rose off a falling edge");
  chk_idle_line: assert property (
    !mode_ff[15] && cfg_ff > 16'h0002 |-> txd_ff && txd_oe_ff == !mode_ff[7])
    else $error("idle transmit line level wrong");
endmodule

// >>> tb/tb_serial_clock_tx_slot.sv
// Self-checking bench: registers, clock rates and slot placement
`timescale 1ns/1ps
`include "sclk_txslot_map.vh"
module tb_serial_clock_tx_slot;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        ext_pin = 1'b0;
  logic        rd_seen = 1'b0;
  wire  [15:0] rdata_ff;
  wire         sck_ff;
  wire         fsync_ff;
  wire         txd_ff;
  wire         txd_oe_ff;
  wire  [15:0] word_ff;
  wire  [3:0]  slot_ff;
  wire         word_v_ff;
  logic [15:0] rq[$];
  logic [15:0] wq[$];
  logic [15:0] lw;
  logic [15:0] rw;
  int          errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  logic [15:0] pq[$];
  logic [15:0] per = 16'h0000;
  logic        sck_q = 1'b0;
  // Clock periods {clock select, mclk cycles}, pin toggles every cycle
  logic [31:0] ptab[6] = '{32'h8000_0040, 32'h8301_000C, 32'h8104_0020,
                           32'h8004_0400, 32'hC000_0002, 32'h4000_0004};
  // Slot setups {slot assign, slot 0 pick, slot 1 pick}: 0 left 1 right 2 idle
  logic [19:0] ftab[4] = '{20'h8180_4, 20'h81C0_0, 20'h8100_8, 20'h0080_6};

  always #4 mclk = ~mclk;
  always @(posedge mclk)
    ext_pin <= ~ext_pin;

  serial_clock_tx_slot #(.ADDR_W(8)) serial_clock_tx_slot_i (.mclk(mclk), .rstn(rstn),
    .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata_ff),
    .ext_master_clock_pin(ext_pin), .sck_ff(sck_ff), .fsync_ff(fsync_ff),
    .txd_ff(txd_ff), .txd_oe_ff(txd_oe_ff));
  codec_model codec_model_i (.mclk(mclk), .rstn(rstn), .sck(sck_ff), .fsync(fsync_ff),
    .txd(txd_ff), .txd_oe(txd_oe_ff), .word_ff(word_ff), .slot_ff(slot_ff),
    .word_v_ff(word_v_ff));

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_read(input logic [15:0] exp, input logic [15:0] got);
    cmp("read data", exp, got);
  endtask
  task automatic cmp_word(input logic [15:0] exp, input logic [15:0] got);
    cmp("slot word", exp, got);
  endtask
  task automatic cmp_period(input logic [15:0] exp, input logic [15:0] got);
    cmp("sck period", exp, got);
  endtask
  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Bus cycles, each taken at the edge after it is driven
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
    rq.push_back(e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
  endtask
  task automatic wait_end();
    do @(posedge mclk); while (!(word_v_ff === 1'b1 && slot_ff === 4'h1));
  endtask
  function automatic logic [15:0] pick(input logic [1:0] s);
    return (s == 2'h0) ? lw : (s == 2'h1) ? rw : 16'hFFFF;
  endfunction

  // Watcher: read data in the cycle after the strobe, slot words from the peer
  always @(posedge mclk)
  begin
    rd_seen <= rd;
    sck_q   <= sck_ff;
    per     <= (sck_ff && !sck_q) ? 16'h0001 : per + 16'h0001;
    if (rd_seen)
      cmp_read(rq.pop_front(), rdata_ff);
    if (word_v_ff && wq.size() > 0)
      cmp_word(wq.pop_front(), word_ff);
    if (sck_ff && !sck_q && pq.size() > 0)
      cmp_period(pq.pop_front(), per);
  end
  // Hang guard
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      errors++;
      test_done();
    end
  end

  initial
  begin
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    void'($urandom(32'hD7A8));
    rd_reg(`OFS_CLOCK_SELECT, `RST_CLOCK_SELECT);
    rd_reg(`OFS_TX_SLOT, `RST_TX_SLOT);
    wr_reg(`OFS_CLOCK_SELECT, 16'hDF04);
    rd_reg(`OFS_CLOCK_SELECT, 16'hDF04);
    wr_reg(`OFS_TX_SLOT, 16'h87C7);
    rd_reg(`OFS_TX_SLOT, 16'h87C7);
    wr_reg(`OFS_SOFT_RESET, 16'h0001);
    rd_reg(`OFS_CLOCK_SELECT, 16'hC000);
    rd_reg(`OFS_TX_SLOT, 16'h0000);
    rd_reg(8'h1C, 16'h0000);
    $display("register test done");
    wr_reg(`OFS_PORT_MODE, 16'hC000);
    foreach (ptab[i])
    begin
      wr_reg(`OFS_CLOCK_SELECT, ptab[i][31:16]);
      repeat (3) @(posedge sck_ff);
      @(negedge mclk);
      pq.push_back(ptab[i][15:0]);
    end
    $display("clock rate test done");
    lw = 16'($urandom);
    rw = 16'($urandom);
    wr_reg(`OFS_TX_LEFT_WORD, lw);
    wr_reg(`OFS_TX_RIGHT_WORD, rw);
    wr_reg(`OFS_CLOCK_SELECT, 16'h8100);
    wr_reg(`OFS_PORT_MODE, 16'h8C00);
    foreach (ftab[i])
    begin
      wr_reg(`OFS_TX_SLOT, ftab[i][19:4]);
      repeat (2) wait_end();
      @(negedge mclk);
      wq.push_back(pick(ftab[i][3:2]));
      wq.push_back(pick(ftab[i][1:0]));
      repeat (2) wait_end();
    end
    $display("slot test done");
    wr_reg(`OFS_PORT_MODE, 16'h0080);
    repeat (4) @(posedge mclk);
    test_done();
  end
endmodule

bind serial_clock_tx_slot sck_slot_monitor #(.ADDR_W(ADDR_W)) sck_slot_monitor_i (
  .mclk(mclk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata_ff(rdata_ff), .ext_master_clock_pin(ext_master_clock_pin), .sck_ff(sck_ff),
  .fsync_ff(fsync_ff), .txd_ff(txd_ff), .txd_oe_ff(txd_oe_ff));

// >>> verilog/baud_gen.v
// Prescaler and output divider producing serial clock half-period ticks
`timescale 1ns/1ps
`include "sclk_txslot_map.vh"

module baud_gen
(
  // Clock and reset
  input  wire       mclk,
  input  wire       rstn,
  input  wire       ce,
  // Control
  input  wire       run,
  input  wire       mtick,
  input  wire [4:0] psc_code,
  input  wire [2:0] div_code,
  // Half-period tick of the divided clock
  output reg        half_tick_ff
);

  reg  [5:0] psc_cnt_ff;
  reg  [4:0] div_cnt_ff;
  wire [5:0] psc_ratio;
  wire [4:0] half_len;
  wire       ptick;

  // Prescale ratio: code 0 divides by 32, others by their value
  assign psc_ratio = (psc_code == 5'h00) ? `PSC_ZERO_RATIO : {1'b0, psc_code};
  // Output stage half period 2^code; codes above max are held at max
  assign half_len  = (div_code > `DIV_MAX_CODE) ? 5'h10 : (5'h01 << div_code);
  assign ptick     = mtick && (psc_cnt_ff == psc_ratio - 6'h01);

  // Cascade counters so the overall ratio is prescale times output ratio
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      psc_cnt_ff   <= 6'h00;
      div_cnt_ff   <= 5'h00;
      half_tick_ff <= 1'b0;
    end
    else if (ce)
    begin
      half_tick_ff <= 1'b0;
      if (!run)
      begin
        psc_cnt_ff <= 6'h00;
        div_cnt_ff <= 5'h00;
      end
      else if (mtick)
      begin
        psc_cnt_ff <= ptick ? 6'h00 : psc_cnt_ff + 6'h01;
        if (ptick)
        begin
          if (div_cnt_ff == half_len - 5'h01)
          begin
            div_cnt_ff   <= 5'h00;
            half_tick_ff <= 1'b1;
          end
          else
            div_cnt_ff <= div_cnt_ff + 5'h01;
        end
      end
    end
  end

endmodule

// >>> verilog/sclk_txslot_map.vh
// Register map, field positions, reset values and encodings of the serial clock and slot block
`ifndef SCLK_TXSLOT_MAP_VH
`define SCLK_TXSLOT_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define OFS_PORT_MODE      8'h00
`define OFS_CLOCK_SELECT   8'h04
`define OFS_TX_SLOT        8'h08
`define OFS_TX_LEFT_WORD   8'h0C
`define OFS_TX_RIGHT_WORD  8'h10
`define OFS_STATUS         8'h14
`define OFS_SOFT_RESET     8'h18

// ----------------------------------------------------------------------------
// Writable masks and reset values
// ----------------------------------------------------------------------------
`define MASK_PORT_MODE     16'hCF80
`define MASK_CLOCK_SELECT  16'hDF07
`define MASK_TX_SLOT       16'h8FCF
`define RST_PORT_MODE      16'h0000
`define RST_CLOCK_SELECT   16'hC000
`define RST_TX_SLOT        16'h0000
`define RST_WORD           16'h0000

// ----------------------------------------------------------------------------
// Port mode fields
// ----------------------------------------------------------------------------
`define MODE_TRMD_HI       15
`define MODE_TRMD_LO       14
`define MODE_FL_HI         11
`define MODE_FL_LO         8
`define MODE_IDLE_FLOAT    7
`define TRMD_MASTER1       2'h2
`define TRMD_MASTER2       2'h3

// ----------------------------------------------------------------------------
// Clock select fields
// ----------------------------------------------------------------------------
`define CKS_SOURCE         15
`define CKS_DIRECT         14
`define CKS_PSC_HI         12
`define CKS_PSC_LO         8
`define CKS_DIV_HI         2
`define CKS_DIV_LO         0
`define PSC_ZERO_RATIO     6'h20
`define DIV_MAX_CODE       3'h4

// ----------------------------------------------------------------------------
// Transmit slot assign fields
// ----------------------------------------------------------------------------
`define TXS_LEFT_EN        15
`define TXS_LEFT_HI        11
`define TXS_LEFT_LO        8
`define TXS_RIGHT_EN       7
`define TXS_REPEAT         6
`define TXS_RIGHT_HI       3
`define TXS_RIGHT_LO       0

// ----------------------------------------------------------------------------
// Soft reset field
// ----------------------------------------------------------------------------
`define SRST_BIT           0

`endif

// >>> verilog/serial_clock_tx_slot.v
// Serial clock generator and transmit slot placement with register port
//
// Contract
// - Generator acts only in master modes 10/11
// - Both registers reset on power-on and soft reset
// - Bit 15 picks pin (0) or system clock (1)
// - Bit 14 picks divided (0) or direct (1) clock
// - Prescaler divides by code, zero means 32
// - Output divider codes 000..100 give 2..32
// - Total ratio is prescale times divider, max 1024
// - Reserved bits read zero, software writes zero
// - Left channel sent only when left enable set
// - Left slot field places upper data word
// - Right channel sent only when right enable set
// - Right slot field places lower data word
// - Repeat bit sends left word in right slot
// - Slots follow frame length and slot size setting
// - Unassigned or disabled slots drive high or float
`timescale 1ns/1ps
`include "sclk_txslot_map.vh"

module serial_clock_tx_slot
#(
  parameter ADDR_W = 8
)
(
  // Clock, reset, enable
  input  wire              mclk,
  input  wire              rstn,
  input  wire              ce,
  // Register port
  input  wire [ADDR_W-1:0] addr,
  input  wire [15:0]       wdata,
  input  wire              wr,
  input  wire              rd,
  output reg  [15:0]       rdata_ff,
  // External master clock pin, synchronous to mclk
  input  wire              ext_master_clock_pin,
  // Serial link
  output reg               sck_ff,
  output reg               fsync_ff,
  output reg               txd_ff,
  output reg               txd_oe_ff
);

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------

  // Bit of a word for a position in the slot, MSB first; 8-bit slots use the upper byte
  function pick_bit;
    input [15:0] word;
    input        slot16;
    input [7:0]  pos;
    begin
      if (slot16)
        pick_bit = word[4'hF - pos[3:0]];
      else
        pick_bit = word[4'hF - {1'b0, pos[2:0]}];
    end
  endfunction

  // Last bit index of a frame for the frame length code
  function [7:0] frame_last;
    input [3:0] fl;
    begin
      case (fl[3:2])
        2'h0:    frame_last = 8'h07;
        2'h1:    frame_last = (8'h10 << fl[1:0]) - 8'h01;
        2'h2:    frame_last = 8'h0F;
        default: frame_last = (8'h20 << fl[1:0]) - 8'h01;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg  [15:0] port_mode_register_ff;
  reg  [15:0] baud_clock_select_ff;
  reg  [15:0] tx_slot_assign_ff;
  reg  [15:0] left_tx_word_ff;
  reg  [15:0] right_tx_word_ff;
  reg  [7:0]  bitpos_ff;
  reg         ext_clk_d_ff;

  wire        sel_mode;
  wire        sel_cks;
  wire        sel_slot;
  wire        sel_left;
  wire        sel_right;
  wire        sel_stat;
  wire        soft_rst;

  assign sel_mode  = (addr == `OFS_PORT_MODE);
  assign sel_cks   = (addr == `OFS_CLOCK_SELECT);
  assign sel_slot  = (addr == `OFS_TX_SLOT);
  assign sel_left  = (addr == `OFS_TX_LEFT_WORD);
  assign sel_right = (addr == `OFS_TX_RIGHT_WORD);
  assign sel_stat  = (addr == `OFS_STATUS);
  assign soft_rst  = wr && (addr == `OFS_SOFT_RESET) && wdata[`SRST_BIT];

  // Register writes; reserved bits are masked so they always hold zero
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      port_mode_register_ff <= `RST_PORT_MODE;
      baud_clock_select_ff  <= `RST_CLOCK_SELECT;
      tx_slot_assign_ff     <= `RST_TX_SLOT;
      left_tx_word_ff       <= `RST_WORD;
      right_tx_word_ff      <= `RST_WORD;
    end
    else if (ce)
    begin
      if (soft_rst)
      begin
        baud_clock_select_ff <= `RST_CLOCK_SELECT;
        tx_slot_assign_ff    <= `RST_TX_SLOT;
      end
      else if (wr)
      begin
        if (sel_cks)
          baud_clock_select_ff <= wdata & `MASK_CLOCK_SELECT;
        if (sel_slot)
          tx_slot_assign_ff <= wdata & `MASK_TX_SLOT;
      end
      if (wr && sel_mode)
        port_mode_register_ff <= wdata & `MASK_PORT_MODE;
      if (wr && sel_left)
        left_tx_word_ff <= wdata;
      if (wr && sel_right)
        right_tx_word_ff <= wdata;
    end
  end

  // --------------------------------------------------------------------------
  // Field decode
  // --------------------------------------------------------------------------
  wire [1:0] transfer_mode;
  wire       master_on;
  wire [3:0] frame_length_select;
  wire       idle_output_float;
  wire       master_clock_source;
  wire       master_clock_direct;
  wire [4:0] prescale_ratio;
  wire [2:0] output_divide_ratio;
  wire       left_tx_enable;
  wire [3:0] left_tx_slot;
  wire       right_tx_enable;
  wire       left_repeat_as_right;
  wire [3:0] right_tx_slot;

  assign transfer_mode        = port_mode_register_ff[`MODE_TRMD_HI:`MODE_TRMD_LO];
  assign master_on            = (transfer_mode == `TRMD_MASTER1) ||
                                (transfer_mode == `TRMD_MASTER2);
  assign frame_length_select  = port_mode_register_ff[`MODE_FL_HI:`MODE_FL_LO];
  assign idle_output_float    = port_mode_register_ff[`MODE_IDLE_FLOAT];
  assign master_clock_source  = baud_clock_select_ff[`CKS_SOURCE];
  assign master_clock_direct  = baud_clock_select_ff[`CKS_DIRECT];
  assign prescale_ratio       = baud_clock_select_ff[`CKS_PSC_HI:`CKS_PSC_LO];
  assign output_divide_ratio  = baud_clock_select_ff[`CKS_DIV_HI:`CKS_DIV_LO];
  assign left_tx_enable       = tx_slot_assign_ff[`TXS_LEFT_EN];
  assign left_tx_slot         = tx_slot_assign_ff[`TXS_LEFT_HI:`TXS_LEFT_LO];
  assign right_tx_enable      = tx_slot_assign_ff[`TXS_RIGHT_EN];
  assign left_repeat_as_right = tx_slot_assign_ff[`TXS_REPEAT];
  assign right_tx_slot        = tx_slot_assign_ff[`TXS_RIGHT_HI:`TXS_RIGHT_LO];

  // --------------------------------------------------------------------------
  // Master clock and generator
  // --------------------------------------------------------------------------
  wire mtick;
  wire gen_half;
  wire half_tick;
  wire gen_run;

  // Pin edge detector for the external master clock
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      ext_clk_d_ff <= 1'b0;
    else if (ce)
      ext_clk_d_ff <= ext_master_clock_pin;
  end

  // Master clock tick: each system cycle or each rising pin edge
  assign mtick = master_clock_source ? 1'b1 :
                 (ext_master_clock_pin && !ext_clk_d_ff);

  // Divider restarts on a new clock setting so the first period after it is whole
  assign gen_run = master_on && !soft_rst && !(wr && sel_cks);

  baud_gen u_baud_gen
  (
    .mclk         (mclk),
    .rstn         (rstn),
    .ce           (ce),
    .run          (gen_run),
    .mtick        (mtick),
    .psc_code     (prescale_ratio),
    .div_code     (output_divide_ratio),
    .half_tick_ff (gen_half)
  );

  // Direct mode follows the master clock itself, otherwise the divided output
  assign half_tick = master_clock_direct ? mtick : gen_half;

  // --------------------------------------------------------------------------
  // Frame position and slot selection
  // --------------------------------------------------------------------------
  wire       slot16;
  wire [3:0] slot_idx;
  wire       fall;
  wire       left_hit;
  wire       right_hit;
  wire [15:0] right_word;
  wire [7:0] last_bit;

  assign slot16     = frame_length_select[3];
  assign last_bit   = frame_last(frame_length_select);
  assign slot_idx   = slot16 ? bitpos_ff[7:4] : bitpos_ff[6:3];
  assign fall       = half_tick && sck_ff;
  assign left_hit   = left_tx_enable && (slot_idx == left_tx_slot);
  assign right_hit  = right_tx_enable && (slot_idx == right_tx_slot);
  assign right_word = left_repeat_as_right ? left_tx_word_ff : right_tx_word_ff;

  // Serial clock toggles and data changes on the falling edge
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      sck_ff    <= 1'b0;
      fsync_ff  <= 1'b0;
      txd_ff    <= 1'b1;
      txd_oe_ff <= 1'b1;
      bitpos_ff <= 8'h00;
    end
    else if (ce)
    begin
      if (!master_on || soft_rst)
      begin
        sck_ff    <= 1'b0;
        fsync_ff  <= 1'b0;
        bitpos_ff <= 8'h00;
        txd_ff    <= 1'b1;
        txd_oe_ff <= !idle_output_float;
      end
      else if (half_tick)
      begin
        sck_ff <= !sck_ff;
        if (fall)
        begin
          fsync_ff  <= (bitpos_ff == 8'h00);
          bitpos_ff <= (bitpos_ff >= last_bit) ? 8'h00 : bitpos_ff + 8'h01;
          if (left_hit)
          begin
            txd_ff    <= pick_bit(left_tx_word_ff, slot16, bitpos_ff);
            txd_oe_ff <= 1'b1;
          end
          else if (right_hit)
          begin
            txd_ff    <= pick_bit(right_word, slot16, bitpos_ff);
            txd_oe_ff <= 1'b1;
          end
          else
          begin
            txd_ff    <= 1'b1;
            txd_oe_ff <= !idle_output_float;
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------------

  // Read data stand one cycle after the strobe; unmapped addresses read zero
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rdata_ff <= 16'h0000;
    else if (ce)
    begin
      rdata_ff <= 16'h0000;
      if (rd)
      begin
        if (sel_mode)
          rdata_ff <= port_mode_register_ff;
        else if (sel_cks)
          rdata_ff <= baud_clock_select_ff;
        else if (sel_slot)
          rdata_ff <= tx_slot_assign_ff;
        else if (sel_left)
          rdata_ff <= left_tx_word_ff;
        else if (sel_right)
          rdata_ff <= right_tx_word_ff;
        else if (sel_stat)
          rdata_ff <= {master_on, sck_ff, 6'h00, bitpos_ff};
      end
    end
  end

endmodule
